// ### core/wwd_top.sv
// window watchdog timer with apb register slave
// Functional notes
// - sixteen-bit up-counter advances once per tick of the selected rate.
// - counter is two cascaded byte counters, low byte carrying into high.
// - service clears the low byte and loads the high byte from reload.
// - after service counting resumes from reload byte times 256.
// - overflow without service sets timeout flag and enters prewarning.
// - prewarning lasts 0x30 counts, then system reset request asserts.
// - service inside enabled window starts prewarning without timeout flag.
// - window spans zero up to window byte with a zero low byte.
// - debug mode freezes the counter, so no service is needed.
// - rate select picks clock divided by 2 (0) or 128 (1).
// - period is 2^(1+6*sel) times (65536 - reload*256) clocks.
// - enabled window with larger bound shortens usable period accordingly.
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module wwd_top (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction, 1 write
    input wire logic [wwd_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [wwd_pkg::DATA_W-1:0] pwdata, // apb write data
    output logic [wwd_pkg::DATA_W-1:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic debug_mode, // debugger halt, asynchronous
    output logic irq, // unmasked status pending
    output logic timeout_nmi_flag, // overflow nmi flag
    output logic system_reset_request // system reset request
);
    // register state
    logic [wwd_pkg::CTRL_W-1:0] ctrl;
    logic [wwd_pkg::CTRL_W-1:0] next_ctrl;
    logic [7:0] reload_high_byte;
    logic [7:0] next_reload_high_byte;
    logic [7:0] window_bound_byte;
    logic [7:0] next_window_bound_byte;
    logic [wwd_pkg::ST_W-1:0] status;
    logic [wwd_pkg::ST_W-1:0] next_status;
    logic [wwd_pkg::ST_W-1:0] mask;
    logic [wwd_pkg::ST_W-1:0] next_mask;
    logic next_irq;

    // bus state
    logic [wwd_pkg::DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // watchdog state
    wwd_pkg::wwd_phase_e phase;
    wwd_pkg::wwd_phase_e next_phase;
    logic [wwd_pkg::PW_W-1:0] pw_cnt;
    logic [wwd_pkg::PW_W-1:0] next_pw_cnt;
    logic next_system_reset_request;

    // debug pin synchroniser
    logic dbg_meta;
    logic dbg_sync;

    // internal nets
    logic setup;
    logic acc_wr;
    logic svc_req;
    logic in_window;
    logic svc_bad;
    logic svc_ok;
    logic enabled;
    logic tick;
    logic cnt_inc;
    logic cnt_ovf;
    logic ev_timeout;
    logic ev_invalid;
    logic ev_reset;
    logic pre_run;
    logic pre_clear;
    logic [15:0] count;
    logic [15:0] window_top;
    logic [wwd_pkg::DATA_W-1:0] rd_word;

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == wwd_pkg::OFF_CTRL) ||
            (a == wwd_pkg::OFF_RELOAD) || (a == wwd_pkg::OFF_WINDOW) ||
            (a == wwd_pkg::OFF_SERVICE) || (a == wwd_pkg::OFF_COUNT) ||
            (a == wwd_pkg::OFF_STATUS) || (a == wwd_pkg::OFF_MASK) ||
            (a == wwd_pkg::OFF_PHASE);
    endfunction : addr_mapped

    function automatic logic wr_hit(input logic [7:0] a,
                                    input logic [7:0] off);
        wr_hit = (a == off);
    endfunction : wr_hit

    function automatic logic phase_counts(input wwd_pkg::wwd_phase_e p);
        phase_counts = (p == wwd_pkg::PH_COUNT);
    endfunction : phase_counts

    function automatic logic phase_warns(input wwd_pkg::wwd_phase_e p);
        phase_warns = (p == wwd_pkg::PH_PREWARN);
    endfunction : phase_warns

    // two flops before anything reads the debug pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_meta <= 1'b0;
            dbg_sync <= 1'b0;
        end else begin
            dbg_meta <= debug_mode;
            dbg_sync <= dbg_meta;
        end
    end

    wwd_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .run(pre_run),
        .clear(pre_clear),
        .slow(ctrl[wwd_pkg::CTRL_RATE_BIT]),
        .tick(tick)
    );

    wwd_counter u_counter (
        .pclk(pclk),
        .presetn(presetn),
        .inc(cnt_inc),
        .load(svc_ok),
        .load_hi(reload_high_byte),
        .count(count),
        .ovf(cnt_ovf)
    );

    // apb strobes and read mux
    // read data is taken at setup, so it stands through the access
    always_comb begin
        setup = psel && !penable;
        acc_wr = psel && penable && pready && pwrite && !pslverr;
        rd_word = '0;
        if (paddr == wwd_pkg::OFF_CTRL) begin
            rd_word[wwd_pkg::CTRL_W-1:0] = ctrl;
        end else if (paddr == wwd_pkg::OFF_RELOAD) begin
            rd_word[7:0] = reload_high_byte;
        end else if (paddr == wwd_pkg::OFF_WINDOW) begin
            rd_word[7:0] = window_bound_byte;
        end else if (paddr == wwd_pkg::OFF_COUNT) begin
            rd_word[15:0] = count;
        end else if (paddr == wwd_pkg::OFF_STATUS) begin
            rd_word[wwd_pkg::ST_W-1:0] = status;
        end else if (paddr == wwd_pkg::OFF_MASK) begin
            rd_word[wwd_pkg::ST_W-1:0] = mask;
        end else if (paddr == wwd_pkg::OFF_PHASE) begin
            rd_word[2:0] = phase;
            rd_word[wwd_pkg::PHASE_PW_LSB +: wwd_pkg::PW_W] = pw_cnt;
        end

        // zero wait states: ready the cycle after setup
        next_pready = setup;
        next_pslverr = setup && !addr_mapped(paddr);
        next_prdata = prdata;
        if (setup && !pwrite) begin
            next_prdata = rd_word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // watchdog decisions
    always_comb begin
        enabled = ctrl[wwd_pkg::CTRL_EN_BIT];
        svc_req = acc_wr && wr_hit(paddr, wwd_pkg::OFF_SERVICE);

        // window bound is inclusive of its top value
        window_top = {window_bound_byte, wwd_pkg::BYTE_ZERO};
        in_window = ctrl[wwd_pkg::CTRL_WIN_BIT] &&
            (count <= window_top);

        // services in prewarning or reset are ignored
        svc_bad = svc_req && phase_counts(phase) && in_window;
        svc_ok = svc_req && phase_counts(phase) && !in_window;

        // counter frozen outside the counting phase
        cnt_inc = tick && enabled && phase_counts(phase);

        // a service in the overflow cycle still counts as in time
        ev_timeout = cnt_ovf && !svc_req;
        ev_invalid = svc_bad;
        ev_reset = tick && phase_warns(phase) &&
            (pw_cnt == wwd_pkg::PREWARN_LAST);

        // prewarning keeps running even with the enable bit cleared
        pre_run = !dbg_sync && (enabled ||
            phase_warns(phase));
        // restart the divider so the next count is a full period
        pre_clear = svc_ok || ev_timeout || ev_invalid;
    end

    // phase machine
    always_comb begin
        next_phase = phase;
        next_pw_cnt = pw_cnt;
        next_system_reset_request = system_reset_request;
        case (phase)
            wwd_pkg::PH_COUNT: begin
                if (ev_timeout || ev_invalid) begin
                    next_phase = wwd_pkg::PH_PREWARN;
                    next_pw_cnt = '0;
                end
            end
            wwd_pkg::PH_PREWARN: begin
                if (ev_reset) begin
                    next_phase = wwd_pkg::PH_RESET;
                    next_system_reset_request = 1'b1;
                end else if (tick) begin
                    next_pw_cnt = pw_cnt + 6'h01;
                end
            end
            wwd_pkg::PH_RESET: begin
                // held until the system reset clears the block
                next_system_reset_request = 1'b1;
            end
            default: begin
                next_phase = wwd_pkg::PH_COUNT;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= wwd_pkg::PH_COUNT;
            pw_cnt <= '0;
            system_reset_request <= 1'b0;
        end else begin
            phase <= next_phase;
            pw_cnt <= next_pw_cnt;
            system_reset_request <= next_system_reset_request;
        end
    end

    // software registers and sticky status
    always_comb begin
        next_ctrl = ctrl;
        next_reload_high_byte = reload_high_byte;
        next_window_bound_byte = window_bound_byte;
        next_mask = mask;
        next_status = status;
        if (acc_wr) begin
            if (wr_hit(paddr, wwd_pkg::OFF_CTRL)) begin
                next_ctrl = pwdata[wwd_pkg::CTRL_W-1:0];
            end else if (wr_hit(paddr, wwd_pkg::OFF_RELOAD)) begin
                next_reload_high_byte = pwdata[7:0];
            end else if (wr_hit(paddr, wwd_pkg::OFF_WINDOW)) begin
                next_window_bound_byte = pwdata[7:0];
            end else if (wr_hit(paddr, wwd_pkg::OFF_MASK)) begin
                next_mask = pwdata[wwd_pkg::ST_W-1:0];
            end else if (wr_hit(paddr, wwd_pkg::OFF_STATUS)) begin
                next_status = status & ~pwdata[wwd_pkg::ST_W-1:0];
            end
            // count and phase are read only; writes there are dropped
        end

        // set wins over a clear in the same cycle
        if (ev_timeout) begin
            next_status[wwd_pkg::ST_TIMEOUT] = 1'b1;
        end
        if (ev_invalid) begin
            next_status[wwd_pkg::ST_INVALID] = 1'b1;
        end
        if (ev_reset) begin
            next_status[wwd_pkg::ST_RESET] = 1'b1;
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= wwd_pkg::CTRL_RST;
            reload_high_byte <= wwd_pkg::RELOAD_RST;
            window_bound_byte <= wwd_pkg::WINDOW_RST;
            mask <= wwd_pkg::MASK_RST;
            status <= wwd_pkg::ST_RST;
            irq <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            reload_high_byte <= next_reload_high_byte;
            window_bound_byte <= next_window_bound_byte;
            mask <= next_mask;
            status <= next_status;
            irq <= next_irq;
        end
    end

    // nmi flag is the sticky timeout status bit itself
    assign timeout_nmi_flag = status[wwd_pkg::ST_TIMEOUT];
endmodule : wwd_top

// ### core/wwd_pkg.sv
// constants and types shared by the window watchdog files
package wwd_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_RELOAD = 8'h04;
    localparam logic [7:0] OFF_WINDOW = 8'h08;
    localparam logic [7:0] OFF_SERVICE = 8'h0C;
    localparam logic [7:0] OFF_COUNT = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_MASK = 8'h18;
    localparam logic [7:0] OFF_PHASE = 8'h1C;

    // control register fields
    localparam int CTRL_W = 3;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_RATE_BIT = 1;
    localparam int CTRL_WIN_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // status / mask fields
    localparam int ST_W = 3;
    localparam int ST_TIMEOUT = 0;
    localparam int ST_INVALID = 1;
    localparam int ST_RESET = 2;
    localparam logic [2:0] ST_RST = 3'h0;
    localparam logic [2:0] MASK_RST = 3'h0;

    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [7:0] WINDOW_RST = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // input rate divider
    localparam int PRE_W = 7;
    localparam int FAST_DIV = 2;
    localparam int SLOW_DIV = 128;
    localparam logic [6:0] FAST_TERM = 7'(FAST_DIV - 1);
    localparam logic [6:0] SLOW_TERM = 7'(SLOW_DIV - 1);

    // prewarning length in watchdog counts
    localparam int PW_W = 6;
    localparam logic [5:0] PREWARN_COUNTS = 6'h30;
    localparam logic [5:0] PREWARN_LAST = 6'(PREWARN_COUNTS - 6'h01);

    // phase register fields
    localparam int PHASE_PW_LSB = 8;

    typedef enum logic [2:0] {
        PH_COUNT = 3'b001,
        PH_PREWARN = 3'b010,
        PH_RESET = 3'b100
    } wwd_phase_e;
endpackage : wwd_pkg

// ### core/wwd_prescaler.sv
// input rate divider: one tick every 2 or 128 clocks
`timescale 1ns/1ps
module wwd_prescaler (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic run, // divider advances
    input wire logic clear, // restart the division
    input wire logic slow, // 1: divide by 128, 0: by 2
    output logic tick // one-cycle count pulse
);
    logic [wwd_pkg::PRE_W-1:0] cnt;
    logic [wwd_pkg::PRE_W-1:0] next_cnt;
    logic [wwd_pkg::PRE_W-1:0] term;
    logic at_term;

    always_comb begin
        term = slow ? wwd_pkg::SLOW_TERM : wwd_pkg::FAST_TERM;
        // rate switch with cnt past the new end still wraps at once
        at_term = (cnt >= term);
        // tick ignores clear: the clear is fed back from tick upstream
        tick = run && at_term;
        next_cnt = cnt;
        if (clear) begin
            next_cnt = '0;
        end else if (run) begin
            next_cnt = at_term ? '0 : cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end
endmodule : wwd_prescaler

// ### core/wwd_counter.sv
// watchdog count: two cascaded byte counters with reload
`timescale 1ns/1ps
module wwd_counter (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic inc, // advance by one
    input wire logic load, // service reload
    input wire logic [7:0] load_hi, // reload high byte
    output logic [15:0] count, // current value
    output logic ovf // wrap from all ones, with inc
);
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] next_lo;
    logic [7:0] next_hi;
    logic lo_carry;

    always_comb begin
        lo_carry = inc && (lo == wwd_pkg::BYTE_MAX);
        ovf = lo_carry && (hi == wwd_pkg::BYTE_MAX);
        next_lo = lo;
        next_hi = hi;
        if (load) begin
            next_lo = wwd_pkg::BYTE_ZERO;
            next_hi = load_hi;
        end else begin
            if (inc) begin
                next_lo = lo + 8'h01;
            end
            if (lo_carry) begin
                next_hi = hi + 8'h01;
            end
        end
    end

    assign count = {hi, lo};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo <= wwd_pkg::BYTE_ZERO;
            hi <= wwd_pkg::BYTE_ZERO;
        end else begin
            lo <= next_lo;
            hi <= next_hi;
        end
    end
endmodule : wwd_counter

// ### verification/wwd_properties.sv
// port assertions for the window watchdog top
`timescale 1ns/1ps
module wwd_properties (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // write
    input wire logic [wwd_pkg::ADDR_W-1:0] paddr, // address
    input wire logic [wwd_pkg::DATA_W-1:0] pwdata, // write data
    input wire logic [wwd_pkg::DATA_W-1:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic debug_mode, // halt
    input wire logic irq, // interrupt
    input wire logic timeout_nmi_flag, // nmi flag
    input wire logic system_reset_request // reset request
);
    logic to_q, next_to_q, armed, next_armed;
    logic [7:0] pw_cyc, next_pw_cyc;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // clocks since the nmi flag rose
    always_comb begin
        next_to_q = timeout_nmi_flag;
        next_armed = armed | (timeout_nmi_flag & ~to_q);
        next_pw_cyc = (pw_cyc == 8'hFF) ? pw_cyc : pw_cyc + 8'h01;
        if (timeout_nmi_flag && !to_q) begin
            next_pw_cyc = 8'h00;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_q <= 1'b0;
            armed <= 1'b0;
            pw_cyc <= 8'h00;
        end else begin
            to_q <= next_to_q;
            armed <= next_armed;
            pw_cyc <= next_pw_cyc;
        end
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    apb_answer_a: assert property (setup_s |=> access_s)
        else $error("no ready after setup");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    unmapped_zero_a: assert property (pslverr |->
        pready && (pwrite || prdata == '0))
        else $error("error without ready or with data");
    release_quiet_a: assert property ($rose(presetn) |->
        !irq && !timeout_nmi_flag && !system_reset_request)
        else $error("outputs active after reset");
    reset_sticky_a: assert property (
        system_reset_request |=> system_reset_request)
        else $error("reset request dropped");
    prewarn_length_a: assert property (
        $rose(system_reset_request) && armed |-> pw_cyc >= 8'h5A)
        else $error("prewarning too short");
    timeout_first_a: assert property (
        $rose(timeout_nmi_flag) |-> !system_reset_request)
        else $error("nmi after reset request");
    flag_sticky_a: assert property ($fell(timeout_nmi_flag) |->
        $past(psel && penable && pwrite && paddr == wwd_pkg::OFF_STATUS
        && pwdata[wwd_pkg::ST_TIMEOUT]))
        else $error("nmi flag cleared without write");
    irq_cause_a: assert property ($rose(irq) |->
        $past(psel && penable && pwrite) || $rose(timeout_nmi_flag)
        || $rose(system_reset_request))
        else $error("irq without cause");
    debug_freeze_a: assert property (debug_mode [*6] |->
        !$rose(timeout_nmi_flag) && !$rose(system_reset_request))
        else $error("watchdog ran in debug");
endmodule : wwd_properties
bind wwd_top wwd_properties u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_mode(debug_mode), .irq(irq), .timeout_nmi_flag(timeout_nmi_flag),
    .system_reset_request(system_reset_request));

// ### verification/wwd_top_test.sv
// self-checking bench for the window watchdog top
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
    failures++; $display("mismatch %s expected %0h seen %0h", nm, e, g); \
    end end
module wwd_top_test;
    logic pclk, presetn, psel, penable, pwrite, debug_mode;
    logic [wwd_pkg::ADDR_W-1:0] paddr;
    logic [wwd_pkg::DATA_W-1:0] pwdata, prdata;
    logic pready, pslverr, irq, timeout_nmi_flag, system_reset_request;
    int failures, compares, seed, cyc, t0, dv;
    logic [32:0] exp_q[$], msk_q[$], e_v, m_v;
    string nm_q[$], s_v;

    wwd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .debug_mode(debug_mode), .irq(irq),
        .timeout_nmi_flag(timeout_nmi_flag),
        .system_reset_request(system_reset_request));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    // read answers against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite
            && exp_q.size() > 0) begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            s_v = nm_q.pop_front();
            `CHK(s_v, e_v, {pslverr, prdata} & m_v)
        end
    end

    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k == 16) begin
            failures++;
            report_and_stop();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [32:0] e,
                      input logic [32:0] m, input string nm);
        exp_q.push_back(e);
        msk_q.push_back(m);
        nm_q.push_back(nm);
        apb(1'b0, a, 32'h00000000);
    endtask : rd

    task automatic wait_for(input logic rq, input int lim);
        int k;
        k = 0;
        while ((rq ? system_reset_request : timeout_nmi_flag) !== 1'b1) begin
            @(posedge pclk);
            k++;
            if (k > lim) begin
                failures++;
                report_and_stop();
            end
        end
    endtask : wait_for

    task automatic do_reset();
        presetn <= 1'b0;
        debug_mode <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("quiet", 3'h0, {irq, timeout_nmi_flag, system_reset_request})
    endtask : do_reset

    initial begin
        repeat (100000) @(posedge pclk);
        failures++;
        report_and_stop();
    end

    initial begin
        seed = 32'h0D4E1A06;
        {psel, penable, pwrite, debug_mode, presetn} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        do_reset();
        wr(8'h20, 32'hFFFFFFFF);
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), (i == 7) ? 33'h1 : 33'h0, '1, "reset value");
        end
        rd(8'h20 | (8'($random(seed)) & 8'hDC), 33'h100000000, '1, "unmapped");
        $display("test reset values done");
        for (int s = 0; s < 2; s++) begin
            dv = s ? 128 : 2;
            wr(wwd_pkg::OFF_RELOAD, 32'h000000FF);
            wr(wwd_pkg::OFF_CTRL, {30'h0, s[0], 1'b1});
            wr(wwd_pkg::OFF_SERVICE, $random(seed));
            t0 = cyc;
            rd(wwd_pkg::OFF_COUNT, 33'hFF00, 33'hFF00, "count");
            wait_for(1'b0, 40000);
            `CHK("period", 1'b1, (cyc - t0) inside {[dv*256:dv*256+3]})
            `CHK("irq masked", 1'b0, irq)
            t0 = cyc;
            wait_for(1'b1, 7000);
            `CHK("prewarn", 1'b1, (cyc - t0) inside {[dv*48-1:dv*48+2]})
            rd(wwd_pkg::OFF_STATUS, 33'h5, 33'h7, "status");
            rd(wwd_pkg::OFF_PHASE, 33'h4, 33'h7, "phase");
            wr(wwd_pkg::OFF_MASK, 32'h1);
            @(posedge pclk);
            `CHK("irq raised", 1'b1, irq)
            wr(wwd_pkg::OFF_STATUS, 32'h1);
            @(posedge pclk);
            `CHK("irq cleared", 2'h0, {irq, timeout_nmi_flag})
            do_reset();
            $display("test timeout done");
        end
        wr(wwd_pkg::OFF_RELOAD, 32'h000000F0);
        wr(wwd_pkg::OFF_WINDOW, 32'h000000F1);
        wr(wwd_pkg::OFF_MASK, 32'h2);
        wr(wwd_pkg::OFF_CTRL, 32'h1);
        wr(wwd_pkg::OFF_SERVICE, $random(seed));
        wr(wwd_pkg::OFF_CTRL, 32'h5);
        wr(wwd_pkg::OFF_SERVICE, $random(seed));
        t0 = cyc;
        @(posedge pclk);
        `CHK("irq window", 2'h2, {irq, timeout_nmi_flag})
        rd(wwd_pkg::OFF_STATUS, 33'h2, 33'h7, "status");
        rd(wwd_pkg::OFF_PHASE, 33'h2, 33'h7, "phase");
        wr(wwd_pkg::OFF_STATUS, 32'h2);
        @(posedge pclk);
        `CHK("irq off", 1'b0, irq)
        wait_for(1'b1, 200);
        `CHK("window reset", 1'b1, (cyc - t0) inside {[95:99]})
        `CHK("no nmi", 1'b0, timeout_nmi_flag)
        do_reset();
        $display("test window done");
        wr(wwd_pkg::OFF_RELOAD, 32'h000000FF);
        wr(wwd_pkg::OFF_CTRL, 32'h1);
        wr(wwd_pkg::OFF_SERVICE, $random(seed));
        t0 = cyc;
        debug_mode <= 1'b1;
        repeat (600) @(posedge pclk);
        `CHK("frozen", 1'b0, timeout_nmi_flag)
        rd(wwd_pkg::OFF_COUNT, 33'hFF00, 33'hFF00, "count frozen");
        debug_mode <= 1'b0;
        wait_for(1'b0, 1000);
        `CHK("resumed", 1'b1, (cyc - t0) > 1000)
        $display("test debug done");
        report_and_stop();
    end
endmodule : wwd_top_test
